/* verilog/ts_irq_map.svh */
// register offsets, flag bit positions and reset values of the status clear block
`ifndef TS_IRQ_MAP_SVH
`define TS_IRQ_MAP_SVH

// ==========================================
// register byte offsets
`define STATUS_OFS 8'h00
`define CLEAR_OFS 8'h04
`define MASK_OFS 8'h08
`define CTRL_OFS 8'h0C

// ==========================================
// flag positions in status, clear and mask, and the global enable bit in control
`define TIME_EVT_LSB 16
`define WRING_LSB 8
`define RXERR_BIT 6
`define RRING0_BIT 4
`define PMAP_BIT 3
`define PASSOC_BIT 2
`define PGRP_BIT 1
`define BWORD_BIT 0
`define GLOBAL_EN_BIT 0

// ==========================================
// field masks
`define TIME_EVT_FIELD 32'h00FF0000
`define WRING_FIELD 32'h0000FF00
`define RXERR_FIELD 32'h00000040
`define RRING0_FIELD 32'h00000010
`define PMAP_FIELD 32'h00000008
`define PASSOC_FIELD 32'h00000004
`define PGRP_FIELD 32'h00000002
`define BWORD_FIELD 32'h00000001
`define FLAG_VALID 32'h00FFFF5F

// ==========================================
// reset values
`define STATUS_RST 32'h00000000
`define MASK_RST 32'h00000000
`define CTRL_RST 1'h0
`define ZERO_WORD 32'h00000000

`endif

/* verilog/ts_irq_pkg.sv */
// types shared by the status clear block and its bench
package ts_irq_pkg;

	// ==========================================
	// event inputs, one-cycle pulses
	typedef struct packed {
		logic [7:0] time_event;
		logic [7:0] write_ring;
		logic rx_packet_error;
		logic read_ring0;
		logic program_map_found;
		logic program_assoc_found;
		logic picture_group_start;
		logic boundary_word;
	} event_t;

	// ==========================================
	// apb request and response
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	// ==========================================
	// whole block state
	typedef struct packed {
		logic [31:0] status;
		logic [31:0] mask;
		logic global_en;
		apb_rsp_t rsp;
		logic irq;
	} state_t;

endpackage

/* verilog/ts_interrupt_status_clear.sv */
// interrupt status flags with write-one-to-clear register, mask and apb slave
// Functional notes
// - clear bits 23..16 written one drop time event flags 7..0; zeros keep them.
// - clear bits 15..8 written one drop write ring flags 7..0; zeros keep them.
// - clear bit 6 written one drops receive packet error flag; zero keeps it.
// - clear bit 4 written one drops read ring 0 flag; zero keeps it.
// - clear bit 3 written one drops program map found flag; zero keeps it.
// - clear bit 2 written one drops program association found flag; zero keeps it.
// - clear bit 1 written one drops picture group start flag; zero keeps it.
// - clear register is write-only, zero after reset; a read clears nothing, reset clears every flag.
// - clear bit 0 written one drops boundary word flag; zero keeps it.
// - flags set and clear regardless of mask bits or global enable.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "ts_irq_map.svh"

module ts_interrupt_status_clear (
	input wire logic pclk,
	input wire logic presetn,
	input wire ts_irq_pkg::apb_req_t apb_req,
	output ts_irq_pkg::apb_rsp_t apb_rsp,
	input wire ts_irq_pkg::event_t events,
	output logic [31:0] flags,
	output logic irq
);
	import ts_irq_pkg::*;

	// ==========================================
	// helpers
	function automatic logic [31:0] pack_events(input event_t e);
		logic [31:0] v;
		v = `ZERO_WORD;
		v[`TIME_EVT_LSB +: 8] = e.time_event;
		v[`WRING_LSB +: 8] = e.write_ring;
		v[`RXERR_BIT] = e.rx_packet_error;
		v[`RRING0_BIT] = e.read_ring0;
		v[`PMAP_BIT] = e.program_map_found;
		v[`PASSOC_BIT] = e.program_assoc_found;
		v[`PGRP_BIT] = e.picture_group_start;
		v[`BWORD_BIT] = e.boundary_word;
		return v;
	endfunction

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	state_t st_reg;
	state_t st_next;
	logic [31:0] set_vec;
	logic [31:0] clr_hit;
	logic commit;
	logic mapped;
	logic [31:0] rd_word;

	// ==========================================
	// decode
	assign set_vec = pack_events(events) & `FLAG_VALID;
	assign commit = apb_req.psel & apb_req.penable & st_reg.rsp.pready;
	assign mapped = addr_is(apb_req.paddr, `STATUS_OFS) | addr_is(apb_req.paddr, `CLEAR_OFS)
		| addr_is(apb_req.paddr, `MASK_OFS) | addr_is(apb_req.paddr, `CTRL_OFS);

	// clear decode, reserved bits dropped
	always_comb begin
		clr_hit = `ZERO_WORD;
		if (commit && apb_req.pwrite) begin
			if (addr_is(apb_req.paddr, `CLEAR_OFS) || addr_is(apb_req.paddr, `STATUS_OFS)) begin
				clr_hit[`TIME_EVT_LSB +: 8] = apb_req.pwdata[`TIME_EVT_LSB +: 8];
				clr_hit[`WRING_LSB +: 8] = apb_req.pwdata[`WRING_LSB +: 8];
				clr_hit[`RXERR_BIT] = apb_req.pwdata[`RXERR_BIT];
				clr_hit[`RRING0_BIT] = apb_req.pwdata[`RRING0_BIT];
				clr_hit[`PMAP_BIT] = apb_req.pwdata[`PMAP_BIT];
				clr_hit[`PASSOC_BIT] = apb_req.pwdata[`PASSOC_BIT];
				clr_hit[`PGRP_BIT] = apb_req.pwdata[`PGRP_BIT];
				clr_hit[`BWORD_BIT] = apb_req.pwdata[`BWORD_BIT];
			end
		end
	end

	always_comb begin
		rd_word = `ZERO_WORD;
		if (addr_is(apb_req.paddr, `STATUS_OFS)) begin
			rd_word = st_reg.status;
		end else if (addr_is(apb_req.paddr, `MASK_OFS)) begin
			rd_word = st_reg.mask;
		end else if (addr_is(apb_req.paddr, `CTRL_OFS)) begin
			rd_word[`GLOBAL_EN_BIT] = st_reg.global_en;
		end
	end

	// ==========================================
	// next state
	always_comb begin
		st_next = st_reg;
		st_next.rsp.pready = 1'b0;
		st_next.status = ((st_reg.status & ~clr_hit) | set_vec) & `FLAG_VALID;
		st_next.irq = st_reg.global_en & (|(st_reg.status & st_reg.mask));
		if (apb_req.psel && !apb_req.penable) begin
			st_next.rsp.pready = 1'b1;
			st_next.rsp.pslverr = !mapped;
			st_next.rsp.prdata = apb_req.pwrite ? `ZERO_WORD : rd_word;
		end
		if (commit && apb_req.pwrite) begin
			if (addr_is(apb_req.paddr, `MASK_OFS)) begin
				st_next.mask = apb_req.pwdata & `FLAG_VALID;
			end
			if (addr_is(apb_req.paddr, `CTRL_OFS)) begin
				st_next.global_en = apb_req.pwdata[`GLOBAL_EN_BIT];
			end
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg.status <= `STATUS_RST;
			st_reg.mask <= `MASK_RST;
			st_reg.global_en <= `CTRL_RST;
			st_reg.rsp.prdata <= `ZERO_WORD;
			st_reg.rsp.pready <= 1'b0;
			st_reg.rsp.pslverr <= 1'b0;
			st_reg.irq <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign apb_rsp = st_reg.rsp;
	assign flags = st_reg.status;
	assign irq = st_reg.irq;

	// ==========================================
	// assertions
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_time_clear;
		(commit && apb_req.pwrite && addr_is(apb_req.paddr, `CLEAR_OFS))
		|=> ((st_reg.status & `TIME_EVT_FIELD) == ((($past(st_reg.status)
			& ~$past(apb_req.pwdata)) | $past(set_vec)) & `TIME_EVT_FIELD));
	endproperty
	a_time_clear: assert property (p_time_clear)
		else $error("time event flags wrong after clear write");

	property p_time_drop;
		(commit && apb_req.pwrite && addr_is(apb_req.paddr, `CLEAR_OFS)
			&& ((apb_req.pwdata & ~set_vec & `TIME_EVT_FIELD) != `ZERO_WORD))
		|=> ((st_reg.status & $past(apb_req.pwdata) & ~$past(set_vec)
			& `TIME_EVT_FIELD) == `ZERO_WORD);
	endproperty
	a_time_drop: assert property (p_time_drop)
		else $error("time event flag not dropped");

	property p_time_keep;
		commit |=> ((flags & $past(flags) & ~$past(apb_req.pwdata) & `TIME_EVT_FIELD)
			== ($past(flags) & ~$past(apb_req.pwdata) & `TIME_EVT_FIELD));
	endproperty
	a_time_keep: assert property (p_time_keep)
		else $error("time event flag lost on zero write");

	property p_wring_clear;
		(commit && apb_req.pwrite && addr_is(apb_req.paddr, `CLEAR_OFS))
		|=> ((st_reg.status & `WRING_FIELD) == ((($past(st_reg.status)
			& ~$past(apb_req.pwdata)) | $past(set_vec)) & `WRING_FIELD));
	endproperty
	a_wring_clear: assert property (p_wring_clear)
		else $error("write ring flags wrong after clear write");

	property p_wring_drop;
		(commit && apb_req.pwrite && addr_is(apb_req.paddr, `CLEAR_OFS)
			&& ((apb_req.pwdata & ~set_vec & `WRING_FIELD) != `ZERO_WORD))
		|=> ((st_reg.status & $past(apb_req.pwdata) & ~$past(set_vec)
			& `WRING_FIELD) == `ZERO_WORD);
	endproperty
	a_wring_drop: assert property (p_wring_drop)
		else $error("write ring flag not dropped");

	property p_wring_keep;
		commit |=> ((flags & $past(flags) & ~$past(apb_req.pwdata) & `WRING_FIELD)
			== ($past(flags) & ~$past(apb_req.pwdata) & `WRING_FIELD));
	endproperty
	a_wring_keep: assert property (p_wring_keep)
		else $error("write ring flag lost on zero write");

	property p_rxerr_clear;
		(commit && apb_req.pwrite && addr_is(apb_req.paddr, `CLEAR_OFS)
			&& apb_req.pwdata[`RXERR_BIT] && !events.rx_packet_error)
		|=> !st_reg.status[`RXERR_BIT]
			##1 (!flags[`RXERR_BIT] || $past(events.rx_packet_error));
	endproperty
	a_rxerr_clear: assert property (p_rxerr_clear)
		else $error("receive error flag not dropped");

	property p_rxerr_keep;
		(commit && apb_req.pwrite && !apb_req.pwdata[`RXERR_BIT] && st_reg.status[`RXERR_BIT])
		|=> st_reg.status[`RXERR_BIT];
	endproperty
	a_rxerr_keep: assert property (p_rxerr_keep)
		else $error("receive error flag lost on zero write");

	property p_rring_clear;
		(commit && apb_req.pwrite && addr_is(apb_req.paddr, `CLEAR_OFS)
			&& apb_req.pwdata[`RRING0_BIT] && !events.read_ring0)
		|=> !flags[`RRING0_BIT];
	endproperty
	a_rring_clear: assert property (p_rring_clear)
		else $error("read ring flag not dropped");

	property p_rring_keep;
		(commit && !apb_req.pwdata[`RRING0_BIT] && st_reg.status[`RRING0_BIT])
		|=> flags[`RRING0_BIT];
	endproperty
	a_rring_keep: assert property (p_rring_keep)
		else $error("read ring flag lost on zero write");

	property p_pmap_clear;
		(commit && apb_req.pwrite && addr_is(apb_req.paddr, `CLEAR_OFS))
		|=> ((flags & `PMAP_FIELD) == ((($past(flags)
			& ~$past(apb_req.pwdata)) | $past(set_vec)) & `PMAP_FIELD));
	endproperty
	a_pmap_clear: assert property (p_pmap_clear)
		else $error("program map flag wrong after write");

	property p_pmap_keep;
		(commit && !apb_req.pwdata[`PMAP_BIT] && flags[`PMAP_BIT]) |=> flags[`PMAP_BIT];
	endproperty
	a_pmap_keep: assert property (p_pmap_keep)
		else $error("program map flag lost on zero write");

	property p_passoc_clear;
		(commit && apb_req.pwrite && addr_is(apb_req.paddr, `CLEAR_OFS)
			&& apb_req.pwdata[`PASSOC_BIT] && !events.program_assoc_found)
		|=> !flags[`PASSOC_BIT];
	endproperty
	a_passoc_clear: assert property (p_passoc_clear)
		else $error("program association flag not dropped");

	property p_passoc_keep;
		(commit && !apb_req.pwdata[`PASSOC_BIT] && flags[`PASSOC_BIT]) |=> flags[`PASSOC_BIT];
	endproperty
	a_passoc_keep: assert property (p_passoc_keep)
		else $error("program association flag lost on zero write");

	property p_pgrp_clear;
		(commit && apb_req.pwrite && addr_is(apb_req.paddr, `CLEAR_OFS)
			&& apb_req.pwdata[`PGRP_BIT] && !events.picture_group_start)
		|=> !flags[`PGRP_BIT];
	endproperty
	a_pgrp_clear: assert property (p_pgrp_clear)
		else $error("picture group flag not dropped");

	property p_pgrp_keep;
		(commit && !apb_req.pwdata[`PGRP_BIT] && flags[`PGRP_BIT]) |=> flags[`PGRP_BIT];
	endproperty
	a_pgrp_keep: assert property (p_pgrp_keep)
		else $error("picture group flag lost on zero write");

	property p_bword_clear;
		(commit && apb_req.pwrite && addr_is(apb_req.paddr, `CLEAR_OFS)
			&& apb_req.pwdata[`BWORD_BIT] && !events.boundary_word)
		|=> !flags[`BWORD_BIT];
	endproperty
	a_bword_clear: assert property (p_bword_clear)
		else $error("boundary word flag not dropped");

	property p_bword_keep;
		(commit && !apb_req.pwdata[`BWORD_BIT] && flags[`BWORD_BIT]) |=> flags[`BWORD_BIT];
	endproperty
	a_bword_keep: assert property (p_bword_keep)
		else $error("boundary word flag lost on zero write");

	property p_clear_reads_zero;
		(commit && !apb_req.pwrite && addr_is(apb_req.paddr, `CLEAR_OFS))
		|-> (apb_rsp.prdata == `ZERO_WORD);
	endproperty
	a_clear_reads_zero: assert property (p_clear_reads_zero)
		else $error("clear register read not zero");

	property p_read_keeps;
		(commit && !apb_req.pwrite && (set_vec == `ZERO_WORD)) |=> (flags == $past(flags));
	endproperty
	a_read_keeps: assert property (p_read_keeps)
		else $error("read changed the flags");

	property p_set_always;
		(set_vec != `ZERO_WORD) |=> ((flags & $past(set_vec)) == $past(set_vec));
	endproperty
	a_set_always: assert property (p_set_always)
		else $error("event did not set its flag");

	property p_irq_level;
		##1 (irq == ($past(st_reg.global_en)
			& (|($past(st_reg.status) & $past(st_reg.mask)))));
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("irq not matching masked flags");

	property p_reserved_zero;
		(flags & ~`FLAG_VALID) == `ZERO_WORD;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved flag bit set");

	property p_pready_pulse;
		(apb_req.psel && !apb_req.penable) |=> apb_rsp.pready ##1 !apb_rsp.pready || apb_req.psel;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse)
		else $error("pready not one cycle after setup");

	property p_unmapped_err;
		(apb_req.psel && !apb_req.penable && !mapped) |=> (apb_rsp.pready && apb_rsp.pslverr);
	endproperty
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("unmapped address without error");

	property p_reset_quiet;
		@(posedge pclk) disable iff (1'b0)
		!presetn |=> ((flags == `ZERO_WORD) && !irq && !apb_rsp.pready);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("state not cleared by reset");

	property p_mask_keeps;
		(commit && apb_req.pwrite && !addr_is(apb_req.paddr, `CLEAR_OFS)
			&& !addr_is(apb_req.paddr, `STATUS_OFS))
		|=> ((flags & $past(flags)) == $past(flags));
	endproperty
	a_mask_keeps: assert property (p_mask_keeps)
		else $error("enable write cleared a flag");

	property p_reserved_write;
		(commit && apb_req.pwrite && addr_is(apb_req.paddr, `CLEAR_OFS)
			&& ((apb_req.pwdata & `FLAG_VALID) == `ZERO_WORD))
		|=> ((flags & $past(flags)) == $past(flags));
	endproperty
	a_reserved_write: assert property (p_reserved_write)
		else $error("reserved clear bit changed a flag");

endmodule

/* verification/ts_interrupt_status_clear_tb.sv */
// self-checking bench of the interrupt status clear block
`timescale 1ns/100ps
`include "ts_irq_map.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
	$display("unexpected %s expected %h seen %h", nm, ex, got); end end

module ts_interrupt_status_clear_tb;
	import ts_irq_pkg::*;
	logic pclk = 1'b0;
	logic presetn;
	apb_req_t apb_req;
	apb_rsp_t apb_rsp;
	event_t events;
	logic [31:0] flags;
	logic irq;
	int err_count = 0;
	int n_tests = 0;
	integer seed = 67220;
	logic [31:0] exp_flags;
	logic [31:0] exp_mask;
	logic [31:0] rd;
	logic [31:0] r;
	logic exp_en;
	logic err;

	// ==========================================
	// clock and design
	always #12.5 pclk = ~pclk;

	ts_interrupt_status_clear u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.apb_req(apb_req),
		.apb_rsp(apb_rsp),
		.events(events),
		.flags(flags),
		.irq(irq)
	);

	// ==========================================
	// expectation helpers
	function automatic logic [31:0] to_flags(event_t e);
		return {8'h00, e.time_event, e.write_ring, 1'b0, e.rx_packet_error, 1'b0, e.read_ring0,
			e.program_map_found, e.program_assoc_found, e.picture_group_start, e.boundary_word};
	endfunction

	function automatic logic exp_irq();
		return exp_en & (|(exp_flags & exp_mask));
	endfunction

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ==========================================
	// bus and event drivers
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		// pready taken at a rising edge, watchdog ends a hang
		@(posedge pclk);
		while (apb_rsp.pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	task automatic pulse(input event_t e);
		@(posedge pclk);
		events <= e;
		@(posedge pclk);
		events <= '0;
		exp_flags = exp_flags | to_flags(e);
	endtask

	task automatic check();
		@(negedge pclk);
		`CHK("flags", exp_flags, flags)
		@(negedge pclk);
		`CHK("irq", exp_irq(), irq)
	endtask

	// ==========================================
	// watchdog
	initial begin
		repeat (5000) @(posedge pclk);
		err_count++;
		give_verdict();
	end

	// ==========================================
	// main sequence
	initial begin
		presetn = 1'b0;
		apb_req = '0;
		events = '0;
		exp_flags = 32'h00000000;
		exp_mask = 32'h00000000;
		exp_en = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		check();
		// walking clear bit over every position
		for (int i = 0; i < 32; i++) begin
			pulse('1);
			apb(1'b0, `CLEAR_OFS, 32'h00000000);
			`CHK("clear read", 32'h00000000, rd)
			check();
			apb(1'b1, `CLEAR_OFS, 32'h00000001 << i);
			exp_flags = exp_flags & ~(32'h00000001 << i);
			check();
		end
		// random events, mask, enable and clears
		for (int k = 0; k < 40; k++) begin
			r = $random(seed);
			pulse(r[21:0]);
			exp_mask = $random(seed);
			r = $random(seed);
			exp_en = r[0];
			apb(1'b1, `MASK_OFS, exp_mask);
			exp_mask = exp_mask & `FLAG_VALID;
			apb(1'b1, `CTRL_OFS, {31'h00000000, exp_en});
			check();
			apb(1'b0, `MASK_OFS, 32'h00000000);
			`CHK("mask read", exp_mask, rd)
			r = $random(seed);
			apb(1'b1, `CLEAR_OFS, r);
			exp_flags = exp_flags & ~r;
			check();
		end
		// status and control read back, status write clears too
		apb(1'b0, `STATUS_OFS, 32'h00000000);
		`CHK("status read", exp_flags, rd)
		apb(1'b0, `CTRL_OFS, 32'h00000000);
		`CHK("ctrl read", 32'(exp_en), rd)
		apb(1'b1, `STATUS_OFS, `TIME_EVT_FIELD);
		exp_flags = exp_flags & ~`TIME_EVT_FIELD;
		check();
		// event and clear in the same cycle, set wins
		fork
			apb(1'b1, `CLEAR_OFS, `FLAG_VALID);
			begin
				repeat (2) @(posedge pclk);
				events <= '1;
				@(posedge pclk);
				events <= '0;
			end
		join
		exp_flags = `FLAG_VALID;
		check();
		// unmapped addresses refused
		pulse('1);
		apb(1'b1, 8'h10, 32'hFFFFFFFF);
		`CHK("slverr write", 1'b1, err)
		apb(1'b0, 8'h05, 32'h00000000);
		`CHK("slverr read", 1'b1, err)
		check();
		give_verdict();
	end
endmodule
